// >>> inc/uic_defs.svh
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH

// Register offsets on the three-bit port address
`define UIC_OFS_DATA        3'h0
`define UIC_OFS_IEN         3'h1
`define UIC_OFS_QCTL        3'h2
`define UIC_OFS_IID         3'h2
`define UIC_OFS_LFMT        3'h3
`define UIC_OFS_MCTL        3'h4
`define UIC_OFS_LSTAT       3'h5
`define UIC_OFS_MSTAT       3'h6

// Interrupt enable fields
`define UIC_IEN_RDA         0
`define UIC_IEN_TXE         1
`define UIC_IEN_RLS         2
`define UIC_IEN_MSI         3

// Queue control fields
`define UIC_QC_EN           0
`define UIC_QC_RXCLR        1
`define UIC_QC_TXCLR        2
`define UIC_QC_TRIG_LO      6

// Line format fields
`define UIC_LF_STOP         2
`define UIC_LF_DIVISOR_LATCH_ACCESS         7

// Modem control output-two bit
`define UIC_MC_INTERRUPT_OUTPUT_GATE         3

// Identification codes, bits 3:0
`define UIC_ID_NONE         4'h1
`define UIC_ID_RLS          4'h6
`define UIC_ID_RDA          4'h4
`define UIC_ID_CTO          4'hC
`define UIC_ID_TXE          4'h2
`define UIC_ID_MSI          4'h0

// Trigger levels in bytes
`define UIC_TRIG_0          5'h01
`define UIC_TRIG_1          5'h04
`define UIC_TRIG_2          5'h08
`define UIC_TRIG_3          5'h0E

// Queue depth and timeout length in character times
`define UIC_QDEPTH          5'h10
`define UIC_TO_CHARS        4

// Reset values
`define UIC_RST_IEN         4'h0
`define UIC_RST_LFMT        8'h03

`endif

// >>> inc/uic_pkg.sv
package uic_pkg;

    // One received character with its error flags
    typedef struct packed {
        logic       brk;
        logic       frame_err;
        logic       parity_err;
        logic [7:0] data;
    } uic_rx_word_t;

    // Line status events from the receiver
    typedef struct packed {
        logic brk;
        logic frame_err;
        logic parity_err;
        logic overrun;
    } uic_rls_evt_t;

    // Character format decoded from the line format register
    typedef struct packed {
        logic [3:0] data_bits;
        logic [1:0] stop_halves_m2;
        logic       divisor_latch_access;
    } uic_format_t;

    // Interrupt source chosen for identification
    typedef enum logic [2:0] {
        UIC_SRC_NONE,
        UIC_SRC_RLS,
        UIC_SRC_RDA,
        UIC_SRC_CTO,
        UIC_SRC_TXE,
        UIC_SRC_MSI
    } uic_src_t;

endpackage : uic_pkg

// >>> hdl/uic_ctrl.sv
`timescale 1ns/1ps
// Function
// RULE1: Transmitter-empty enable lets an interrupt follow the transmit holding or queue emptying.
// RULE2: Line-status enable raises an interrupt on overrun, parity, framing or break.
// RULE3: Modem-status enable raises interrupt on modem bit change; enable bits 7:4 read zero.
// RULE4: Queue control is write-only at offset 2, shared with identification; no DMA.
// RULE5: Control bit 0 enables both queues; clearing it, or leaving queue mode, empties them.
// RULE6: Software sets control bit 0 in every write programming other control bits.
// RULE7: Control bit 1 empties receive queue, zeroes counter, keeps shift register; self-clearing.
// RULE8: Control bit 2 empties transmit queue, zeroes counter, keeps shift register; self-clearing.
// RULE9: Control bit 3 has no effect; bits 4 and 5 are reserved.
// RULE10: Control bits 7:6 select receive trigger level of 1, 4, 8 or 14 bytes.
// RULE11: Priority: line status, data available or timeout, transmitter empty, modem status.
// RULE12: The identification value is frozen while the host reads it.
// RULE13: Identification bit 0 is zero while an enabled interrupt is pending, else one.
// RULE14: Identification codes: 0001 none, 0110, 0100, 1100, 0010, 0000 by source.
// RULE15: Identification bit 3 reads zero outside queue mode, set with bit 2 on timeout.
// RULE16: Identification bits 5:4 read zero; bits 7:6 read one while queues enabled.
// RULE17: Timeout after 4 idle character times with data queued; reading receive buffer clears.
// RULE18: Line status read clears line status; buffer read or below trigger clears data; modem read.
// RULE19: Transmitter-empty clears on identification read reporting it, or holding register write.
// RULE20: Line format bits 1:0 select 5, 6, 7 or 8 data bits.
// RULE21: Line format bit 2 gives one stop bit, or 1.5 for 5-bit and 2 otherwise.
// RULE22: The receiver checks only the first stop bit of each character.
// RULE23: Enable bit 0 enables data available and, in queue mode, character timeout.
// RULE24: Divisor latch access bit redirects offsets 0 and 1 to divisor bytes.
// RULE25: The interrupt output is enabled only while the output-two bit is one.
// RULE26: Both queues hold 16 characters; receive entries carry per-character error flags.
`include "uic_defs.svh"

module uic_ctrl
    import uic_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         arst_n_in,
    // Host register port
    input  wire logic [2:0]   addr_in,
    input  wire logic         rd_in,
    input  wire logic         wr_in,
    input  wire logic [7:0]   wdata_in,
    output logic      [7:0]   rdata_out,
    // Receive stream from the shift register
    input  wire logic         rx_valid_in,
    output logic              rx_ready_out,
    input  wire uic_rx_word_t rx_word_in,
    input  wire uic_rls_evt_t rls_evt_in,
    input  wire logic         char_tick_in,
    input  wire logic         msr_change_in,
    input  wire logic [7:0]   msr_in,
    input  wire logic [7:0]   lsr_low_in,
    input  wire logic [7:0]   mctl_in,
    // Transmit stream to the shift register
    output logic              tx_valid_out,
    input  wire logic         tx_ready_in,
    output logic      [7:0]   tx_data_out,
    // Format and interrupt
    output uic_format_t       format_out,
    output logic              divisor_sel_out,
    output logic              irq_out,
    output logic              irq_oe_out
);
    localparam int DW = 11;

    // Reset release through two flops
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Access decode
    logic divisor_latch_access, rd_data, wr_data, rd_iid, wr_qctl;
    assign rd_data = rd_in && addr_in == `UIC_OFS_DATA && !divisor_latch_access;
    assign wr_data = wr_in && addr_in == `UIC_OFS_DATA && !divisor_latch_access;
    assign rd_iid  = rd_in && addr_in == `UIC_OFS_IID;
    assign wr_qctl = wr_in && addr_in == `UIC_OFS_QCTL; // RULE4

    // Register state
    logic [3:0] ien_q, ien_d;
    logic [7:0] lfmt_q, lfmt_d;
    logic       qen_q, qen_d, rx_flush, tx_flush;
    logic [1:0] trig_q, trig_d;
    always_comb
    begin
        ien_d    = ien_q;
        lfmt_d   = lfmt_q;
        qen_d    = qen_q;
        trig_d   = trig_q;
        rx_flush = 1'b0;
        tx_flush = 1'b0;
        if (wr_in && addr_in == `UIC_OFS_IEN && !divisor_latch_access)
            ien_d = wdata_in[3:0]; // RULE3
        if (wr_in && addr_in == `UIC_OFS_LFMT)
            lfmt_d = wdata_in;
        if (wr_qctl)
        begin
            qen_d = wdata_in[`UIC_QC_EN]; // RULE5
            // Other fields only take with bit 0 set; bit 3 and bits 5:4 ignored
            if (wdata_in[`UIC_QC_EN]) // RULE6 RULE9
            begin
                trig_d   = wdata_in[`UIC_QC_TRIG_LO +: 2]; // RULE10
                rx_flush = wdata_in[`UIC_QC_RXCLR]; // RULE7
                tx_flush = wdata_in[`UIC_QC_TXCLR]; // RULE8
            end
            else
            begin
                rx_flush = 1'b1; // RULE5
                tx_flush = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ien_q  <= `UIC_RST_IEN;
            lfmt_q <= `UIC_RST_LFMT;
            qen_q  <= 1'b0;
            trig_q <= 2'h0;
        end
        else
        begin
            ien_q  <= ien_d;
            lfmt_q <= lfmt_d;
            qen_q  <= qen_d;
            trig_q <= trig_d;
        end
    end
    assign divisor_latch_access            = lfmt_q[`UIC_LF_DIVISOR_LATCH_ACCESS];
    assign divisor_sel_out = divisor_latch_access && addr_in[2:1] == 2'h0; // RULE24
    // Format decode; the receiver samples the first stop bit only
    always_comb
    begin
        format_out.data_bits      = 4'h5 + {2'h0, lfmt_q[1:0]}; // RULE20
        format_out.stop_halves_m2 = !lfmt_q[`UIC_LF_STOP] ? 2'h0 :
                                    (lfmt_q[1:0] == 2'h0 ? 2'h1 : 2'h2); // RULE21 RULE22
        format_out.divisor_latch_access           = divisor_latch_access;
    end

    // Receive queue, 16 deep with error flags; depth 1 outside queue mode
    logic [DW-1:0] rxq_mem [0:15]; // RULE26
    logic [3:0]    rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
    logic [4:0]    rx_cnt_q, rx_cnt_d, rx_cap;
    logic          rx_push, rx_pop;
    assign rx_cap       = qen_q ? `UIC_QDEPTH : 5'h01;
    assign rx_ready_out = rx_cnt_q < rx_cap && !rx_flush;
    assign rx_push      = rx_valid_in && rx_ready_out;
    assign rx_pop       = rd_data && rx_cnt_q != 5'h00;
    always_comb
    begin
        rx_wp_d  = rx_wp_q + {3'h0, rx_push};
        rx_rp_d  = rx_rp_q + {3'h0, rx_pop};
        rx_cnt_d = rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
        if (rx_flush)
        begin
            rx_wp_d  = 4'h0; // RULE7
            rx_rp_d  = 4'h0;
            rx_cnt_d = 5'h00;
        end
    end
    always_ff @(posedge mclk_in)
    begin
        if (rx_push)
            rxq_mem[rx_wp_q] <= rx_word_in;
    end

    // Transmit queue, 16 deep; stalls on the shift register's ready
    logic [7:0] txq_mem [0:15]; // RULE26
    logic [3:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic       tx_push, tx_pop;
    assign tx_push      = wr_data && tx_cnt_q < (qen_q ? `UIC_QDEPTH : 5'h01);
    assign tx_valid_out = tx_cnt_q != 5'h00;
    assign tx_pop       = tx_valid_out && tx_ready_in;
    always_comb
    begin
        tx_wp_d  = tx_wp_q + {3'h0, tx_push};
        tx_rp_d  = tx_rp_q + {3'h0, tx_pop};
        tx_cnt_d = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
        if (tx_flush)
        begin
            tx_wp_d  = 4'h0; // RULE8
            tx_rp_d  = 4'h0;
            tx_cnt_d = 5'h00;
        end
    end
    always_ff @(posedge mclk_in)
    begin
        if (tx_push)
            txq_mem[tx_wp_q] <= wdata_in;
    end
    assign tx_data_out = txq_mem[tx_rp_q];

    // Interrupt sources
    logic       rls_q, rls_d, msi_q, msi_d, txe_q, txe_d, cto_q, cto_d;
    logic [2:0] idle_q, idle_d;
    logic       rda, iid_rd_q, txe_rep;
    logic [4:0] trig_lvl;
    // Receive trigger level in bytes
    assign trig_lvl = trig_q[1] ? (trig_q[0] ? `UIC_TRIG_3 : `UIC_TRIG_2) :
                                  (trig_q[0] ? `UIC_TRIG_1 : `UIC_TRIG_0); // RULE10
    // Data available drops as soon as the count falls below trigger
    assign rda = rx_cnt_q >= (qen_q ? trig_lvl : 5'h01); // RULE18
    always_comb
    begin
        // Events win over clears in the same cycle
        rls_d = rls_q;
        if (rd_in && addr_in == `UIC_OFS_LSTAT)
            rls_d = 1'b0; // RULE18
        if (|rls_evt_in)
            rls_d = 1'b1; // RULE2
        msi_d = msi_q;
        if (rd_in && addr_in == `UIC_OFS_MSTAT)
            msi_d = 1'b0; // RULE18
        if (msr_change_in)
            msi_d = 1'b1; // RULE3
        txe_d = txe_q;
        if (wr_data || (iid_rd_q && !rd_iid && txe_rep))
            txe_d = 1'b0; // RULE19
        if (tx_cnt_q == 5'h01 && tx_pop && !tx_push)
            txe_d = 1'b1; // RULE1
        if (tx_flush)
            txe_d = 1'b1;
        // Idle count in character times while data is queued
        idle_d = idle_q;
        cto_d  = cto_q;
        if (rx_push || rx_pop || rx_flush || !qen_q || rx_cnt_q == 5'h00)
        begin
            idle_d = 3'h0; // RULE17
            cto_d  = 1'b0;
        end
        else if (char_tick_in && !cto_q)
        begin
            idle_d = idle_q + 3'h1;
            if (idle_q == 3'(`UIC_TO_CHARS - 1))
                cto_d = 1'b1; // RULE17
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rls_q  <= 1'b0;
            msi_q  <= 1'b0;
            txe_q  <= 1'b1;
            cto_q  <= 1'b0;
            idle_q <= 3'h0;
        end
        else
        begin
            rls_q  <= rls_d;
            msi_q  <= msi_d;
            txe_q  <= txe_d;
            cto_q  <= cto_d;
            idle_q <= idle_d;
        end
    end
    // Prioritised source selection among enabled sources
    uic_src_t src;
    always_comb
    begin
        if (rls_q && ien_q[`UIC_IEN_RLS])
            src = UIC_SRC_RLS; // RULE11
        else if (rda && ien_q[`UIC_IEN_RDA])
            src = UIC_SRC_RDA; // RULE23
        else if (cto_q && ien_q[`UIC_IEN_RDA])
            src = UIC_SRC_CTO; // RULE23
        else if (txe_q && ien_q[`UIC_IEN_TXE])
            src = UIC_SRC_TXE; // RULE1
        else if (msi_q && ien_q[`UIC_IEN_MSI])
            src = UIC_SRC_MSI; // RULE3
        else
            src = UIC_SRC_NONE;
    end
    // Identification value, frozen for the length of a read
    logic [7:0] iid_live, iid_q, iid_d;
    always_comb
    begin
        unique case (src)
            UIC_SRC_RLS: iid_live[3:0] = `UIC_ID_RLS; // RULE14
            UIC_SRC_RDA: iid_live[3:0] = `UIC_ID_RDA;
            UIC_SRC_CTO: iid_live[3:0] = `UIC_ID_CTO; // RULE15
            UIC_SRC_TXE: iid_live[3:0] = `UIC_ID_TXE;
            UIC_SRC_MSI: iid_live[3:0] = `UIC_ID_MSI;
            UIC_SRC_NONE: iid_live[3:0] = `UIC_ID_NONE; // RULE13
        endcase
        iid_live[5:4] = 2'h0; // RULE16
        iid_live[7:6] = {2{qen_q}};
        iid_d = (rd_iid && iid_rd_q) ? iid_q : iid_live; // RULE12
    end
    always_ff @(posedge mclk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            iid_q    <= {4'h0, `UIC_ID_NONE};
            iid_rd_q <= 1'b0;
            txe_rep  <= 1'b0;
        end
        else
        begin
            iid_q    <= iid_d;
            iid_rd_q <= rd_iid;
            txe_rep  <= rd_iid ? (iid_d[3:0] == `UIC_ID_TXE) : txe_rep;
        end
    end
    // Read data mux, registered
    logic [7:0] rdata_d;
    logic [DW-1:0] rx_head;
    assign rx_head = rxq_mem[rx_rp_q];
    always_comb
    begin
        rdata_d = 8'h00;
        if (rd_in)
        begin
            unique case (addr_in)
                `UIC_OFS_DATA:  rdata_d = divisor_latch_access ? 8'h00 : rx_head[7:0];
                `UIC_OFS_IEN:   rdata_d = divisor_latch_access ? 8'h00 : {4'h0, ien_q}; // RULE3
                `UIC_OFS_IID:   rdata_d = iid_d;
                `UIC_OFS_LFMT:  rdata_d = lfmt_q;
                `UIC_OFS_LSTAT: rdata_d = lsr_low_in;
                `UIC_OFS_MSTAT: rdata_d = msr_in;
                default:        rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rdata_out <= 8'h00;
            rx_wp_q   <= 4'h0;
            rx_rp_q   <= 4'h0;
            rx_cnt_q  <= 5'h00;
            tx_wp_q   <= 4'h0;
            tx_rp_q   <= 4'h0;
            tx_cnt_q  <= 5'h00;
            irq_out   <= 1'b0;
        end
        else
        begin
            rdata_out <= rdata_d;
            rx_wp_q   <= rx_wp_d;
            rx_rp_q   <= rx_rp_d;
            rx_cnt_q  <= rx_cnt_d;
            tx_wp_q   <= tx_wp_d;
            tx_rp_q   <= tx_rp_d;
            tx_cnt_q  <= tx_cnt_d;
            irq_out   <= src != UIC_SRC_NONE && mctl_in[`UIC_MC_INTERRUPT_OUTPUT_GATE]; // RULE25
        end
    end
    // Interrupt pin driven only while output-two is set
    assign irq_oe_out = mctl_in[`UIC_MC_INTERRUPT_OUTPUT_GATE]; // RULE25
endmodule : uic_ctrl

// >>> sim/uic_ctrl_props.sv
`timescale 1ns/1ps
module uic_ctrl_props
    import uic_pkg::*;
(
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        arst_n_in,
    // Host port
    input wire logic [2:0]  addr_in,
    input wire logic        rd_in,
    input wire logic        wr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic [7:0]  rdata_out,
    // Transmit side, format and gate
    input wire logic        tx_valid_out,
    input wire logic [7:0]  mctl_in,
    input wire uic_format_t format_out,
    input wire logic        divisor_sel_out,
    input wire logic        irq_oe_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    // Register port relations
    a_gate_follows_mctl: assert property (irq_oe_out == mctl_in[3])
        else $error("interrupt gate differs from modem control bit 3");
    a_divisor_sel_map: assert property (
        divisor_sel_out == (format_out.divisor_latch_access && addr_in < 3'h2))
        else $error("divisor select wrong");
    a_length_follows_write: assert property ((wr_in && addr_in == 3'h3)
        |=> format_out.data_bits == 4'h5 + $past(wdata_in[1:0]))
        else $error("data length wrong");
    a_stop_follows_write: assert property ((wr_in && addr_in == 3'h3) |=>
        format_out.stop_halves_m2 == (!$past(wdata_in[2]) ? 2'h0 :
        ($past(wdata_in[1:0]) == 2'h0 ? 2'h1 : 2'h2)))
        else $error("stop length wrong");
    a_enable_high_zero: assert property (
        (rd_in && addr_in == 3'h1 && !format_out.divisor_latch_access) |=> rdata_out[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    a_ident_fields_legal: assert property ((rd_in && addr_in == 3'h2) |=>
        rdata_out[5:4] == 2'h0 && (!rdata_out[0] || rdata_out[3:1] == 3'h0)
        && (!rdata_out[3] || rdata_out[2]))
        else $error("identification fields illegal");
    a_ident_frozen: assert property ((rd_in && addr_in == 3'h2
        && $past(rd_in && addr_in == 3'h2)) |=> $stable(rdata_out))
        else $error("identification changed during read");
    a_tx_word_queued: assert property (
        (wr_in && addr_in == 3'h0 && !format_out.divisor_latch_access) |=> tx_valid_out)
        else $error("written word not offered");
endmodule : uic_ctrl_props

bind uic_ctrl uic_ctrl_props u_props (.mclk_in, .arst_n_in, .addr_in, .rd_in, .wr_in,
    .wdata_in, .rdata_out, .tx_valid_out, .mctl_in, .format_out, .divisor_sel_out,
    .irq_oe_out);

// >>> sim/uic_far_model.sv
`timescale 1ns/1ps
module uic_far_model
    import uic_pkg::*;
(
    // Clock
    input wire logic     mclk_in,
    // Receive stream into the block
    input wire logic     rx_ready_in,
    output logic         rx_valid_out,
    output uic_rx_word_t rx_word_out,
    output logic         char_tick_out,
    // Transmit stream out of the block
    input wire logic     tx_valid_in,
    input wire logic [7:0] tx_data_in,
    output logic         tx_ready_out,
    output logic         stuck_out
);
    logic [7:0] got_tx[$];
    logic       hold = 1'b0;
    logic [3:0] lf = 4'h5;

    initial
    begin
        rx_valid_out = 1'b0;
        rx_word_out = '0;
        char_tick_out = 1'b0;
        tx_ready_out = 1'b0;
        stuck_out = 1'b0;
    end

    // Stall the transmit side on a pattern, or fully while held
    always @(negedge mclk_in)
    begin
        lf <= {lf[2:0], lf[3] ^ lf[2]};
        tx_ready_out <= !hold && lf[0];
    end

    // Collect each word the block hands over
    always @(posedge mclk_in)
        if (tx_valid_in && tx_ready_out)
            got_tx.push_back(tx_data_in);

    // Offer one received word until taken
    task send(input logic [7:0] d);
        int n;
        n = 0;
        @(negedge mclk_in);
        rx_valid_out = 1'b1;
        rx_word_out = {3'h0, d};
        do
        begin
            @(posedge mclk_in);
            n++;
        end while (!rx_ready_in && n < 200);
        if (n >= 200)
            stuck_out = 1'b1;
        @(negedge mclk_in);
        rx_valid_out = 1'b0;
        rx_word_out = ~rx_word_out; // Released word is not left standing
    endtask : send

    // Character time pulses
    task ticks(input int n);
        repeat (n)
        begin
            @(negedge mclk_in) char_tick_out = 1'b1;
            @(negedge mclk_in) char_tick_out = 1'b0;
        end
    endtask : ticks
endmodule : uic_far_model

// >>> sim/uic_ctrl_test.sv
`timescale 1ns/1ps
module uic_ctrl_test
    import uic_pkg::*;
;
    logic mclk_in, arst_n_in, rd_in, wr_in, rx_valid_in, rx_ready_out, char_tick_in;
    logic msr_change_in, tx_valid_out, tx_ready_in, divisor_sel_out, irq_out, irq_oe_out;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out, msr_in, lsr_low_in, mctl_in, tx_data_out;
    uic_rx_word_t rx_word_in;
    uic_rls_evt_t rls_evt_in;
    uic_format_t  format_out;
    logic stuck, rd_v;
    logic [31:0] rs = 32'h3A7B;
    logic [15:0] expq[$];
    logic [7:0] sent[$], txq[$];
    int err_total, tests_run, lv[4] = '{1, 4, 8, 14};

    uic_ctrl u_dut (.mclk_in, .arst_n_in, .addr_in, .rd_in, .wr_in, .wdata_in, .rdata_out,
        .rx_valid_in, .rx_ready_out, .rx_word_in, .rls_evt_in, .char_tick_in, .msr_change_in,
        .msr_in, .lsr_low_in, .mctl_in, .tx_valid_out, .tx_ready_in, .tx_data_out,
        .format_out, .divisor_sel_out, .irq_out, .irq_oe_out);
    uic_far_model u_far (.mclk_in, .rx_ready_in(rx_ready_out), .rx_valid_out(rx_valid_in),
        .rx_word_out(rx_word_in), .char_tick_out(char_tick_in), .tx_valid_in(tx_valid_out),
        .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in), .stuck_out(stuck));

    function logic [31:0] nxt();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : nxt

    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk

    task report_and_stop();
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge mclk_in);
        wr_in = 1'b0;
        wdata_in = ~d;
    endtask : wr

    // Read held n cycles; one note per cycle
    task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF,
            input int n = 1);
        @(negedge mclk_in);
        addr_in = a;
        rd_in = 1'b1;
        repeat (n)
        begin
            expq.push_back({e, m});
            @(negedge mclk_in);
        end
        rd_in = 1'b0;
    endtask : rd

    task rx(input int n);
        logic [7:0] d;
        repeat (n)
        begin
            d = 8'(nxt());
            sent.push_back(d);
            u_far.send(d);
        end
    endtask : rx

    task drain(input int n);
        repeat (n) rd(3'h0, sent.pop_front());
    endtask : drain

    task txw(input logic [31:0] r);
        txq.push_back(r[7:0]);
        wr(3'h0, r[7:0]);
    endtask : txw

    task wait_tx();
        int n;
        n = 0;
        while (tx_valid_out !== 1'b0 && n < 200)
        begin
            @(negedge mclk_in);
            n++;
        end
        chk(n < 200, "transmit never drained");
        repeat (3) @(negedge mclk_in);
    endtask : wait_tx

    // Compare each read result with the oldest note
    always @(posedge mclk_in) rd_v <= rd_in;
    always @(negedge mclk_in)
        if (rd_v === 1'b1)
        begin
            if (expq.size() == 0)
                chk(1'b0, "read without note");
            else
                chk((rdata_out & expq[0][7:0]) === (expq[0][15:8] & expq[0][7:0]),
                    "read data");
            if (expq.size() > 0)
                void'(expq.pop_front());
        end

    initial
    begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end

    initial
    begin
        repeat (60000) @(posedge mclk_in);
        chk(1'b0, "run timed out");
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        {arst_n_in, rd_in, wr_in, msr_change_in} = 4'h0;
        {addr_in, wdata_in, rls_evt_in} = '0;
        msr_in = 8'(nxt());
        lsr_low_in = 8'(nxt());
        mctl_in = 8'h08;
        repeat (10) @(posedge mclk_in);
        @(negedge mclk_in) arst_n_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        rd(3'h1, 8'h00);
        rd(3'h3, 8'h03);
        rd(3'h2, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            wr(3'h3, {5'h07, i[2:0]});
            rd(3'h3, {5'h07, i[2:0]});
        end
        wr(3'h3, 8'h83);
        rd(3'h0, 8'h00);
        chk(divisor_sel_out === 1'b1, "divisor bytes not selected");
        wr(3'h3, 8'h03);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'h0F);
        rd(3'h2, 8'h02);
        rd(3'h2, 8'h01);
        wr(3'h1, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wr(3'h2, {i[1:0], 6'h3F});
            rx(lv[i] - 1);
            rd(3'h2, 8'hC1);
            rx(1);
            rd(3'h2, 8'hC4);
            drain(lv[i]);
        end
        rx(1);
        u_far.ticks(3);
        rd(3'h2, 8'hC1);
        u_far.ticks(1);
        rd(3'h2, 8'hCC);
        drain(1);
        rd(3'h2, 8'hC1);
        wr(3'h2, 8'h01);
        rx(2);
        rd(3'h2, 8'hC4);
        wr(3'h2, 8'h03);
        sent.delete();
        rd(3'h2, 8'hC1);
        rx(1);
        wr(3'h2, 8'h00);
        sent.delete();
        rd(3'h2, 8'h01);
        rx(1);
        chk(rx_ready_out === 1'b0, "single word mode not full");
        drain(1);
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h0F);
        txw(nxt());
        wait_tx();
        @(negedge mclk_in) {msr_change_in, rls_evt_in} = 5'h11;
        @(negedge mclk_in) {msr_change_in, rls_evt_in} = 5'h00;
        rx(1);
        rd(3'h2, 8'hC6);
        chk(irq_out === 1'b1, "interrupt not raised");
        rd(3'h5, lsr_low_in, 8'h1F);
        rd(3'h2, 8'hC4);
        drain(1);
        rd(3'h2, 8'hC2);
        rd(3'h2, 8'hC0);
        rd(3'h6, msr_in);
        rd(3'h2, 8'hC1);
        mctl_in = 8'h00;
        txw(nxt());
        wait_tx();
        fork
            rd(3'h2, 8'hC2, 8'hFF, 3);
            begin
                repeat (2) @(negedge mclk_in);
                rls_evt_in = 4'h1;
                @(negedge mclk_in) rls_evt_in = 4'h0;
            end
        join
        rd(3'h2, 8'hC6);
        chk(irq_out === 1'b0, "interrupt not gated off");
        rd(3'h5, lsr_low_in, 8'h1F);
        rd(3'h2, 8'hC1);
        u_far.hold = 1'b1;
        repeat (3) wr(3'h0, 8'(nxt()));
        wr(3'h2, 8'h05);
        u_far.hold = 1'b0;
        txw(nxt());
        txw(nxt());
        wait_tx();
        chk(u_far.got_tx.size() == txq.size(), "transmit count");
        foreach (txq[k]) chk(u_far.got_tx[k] === txq[k], "transmit word");
        chk(stuck === 1'b0 && expq.size() == 0, "stream stalled");
        report_and_stop();
    end
endmodule : uic_ctrl_test
